// ### sfse_top.sv
// live fault status, fault latch enable and latched fault registers
// assumes an SMBus engine presenting one command with one word strobe,
// comparator fault levels asynchronous to mclk, servo qualifiers on mclk
// the byte engine handles SMBus framing and passes whole 16-bit words;
// the servo logic runs one single servo for each one-cycle request pulse
//
// How it works
// R1: bits 0..13 show live faults, 15:14 zero
// R2: live bit reads 0 without fault
// R3: live bits follow comparators, never held
// R4: enable bit low forces latched bit zero
// R5: enable bit high lets live fault latch
// R6: bit 14 re-servos channel zero on fault
// R7: bit 15 re-servos channel one on fault
// R8: reading latched register clears latched bits
// R9: clearing enable clears latched bit at once
// R10: live at 00 read-only, enable at 08
// R11: re-servo request on fault rising edge only
module sfse_top
	import sfse_pkg::*;
(
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rst_n,
	// comparator fault levels, asynchronous
	input  wire logic [SFSE_FAULT_W-1:0] fault_cond,
	// servo qualifiers from the servo and monitor logic
	input  wire logic                    servo_enabled_zero,
	input  wire logic                    repeat_servo_zero,
	input  wire logic                    monitor_on_zero,
	input  wire logic                    servo_enabled_one,
	input  wire logic                    repeat_servo_one,
	input  wire logic                    monitor_on_one,
	// command port
	input  wire logic [7:0]              cmd_code,
	input  wire logic                    cmd_rd,
	input  wire logic                    cmd_wr,
	input  wire logic [SFSE_WORD_W-1:0]  cmd_wdata,
	output logic      [SFSE_WORD_W-1:0]  cmd_rdata,
	output logic                         cmd_ack,
	output logic                         cmd_nack,
	// status out
	output logic      [SFSE_FAULT_W-1:0] live_fault_status,
	output logic      [SFSE_FAULT_W-1:0] latched_fault_status,
	output logic      [SFSE_WORD_W-1:0]  fault_latch_enable,
	output logic                         reservo_req_zero,
	output logic                         reservo_req_one
);

	typedef struct packed {
		logic [SFSE_FAULT_W-1:0] live_prev;
		logic [SFSE_WORD_W-1:0]  enable;
		logic [SFSE_FAULT_W-1:0] latched;
		logic [SFSE_WORD_W-1:0]  rdata;
		logic                    ack;
		logic                    nack;
		logic                    req_zero;
		logic                    req_one;
	} sfse_state_s;

	sfse_state_s             st_r;
	sfse_state_s             st_nxt;
	logic [1:0]              rst_sync_r;
	logic                    rst_int_n;
	logic [SFSE_FAULT_W-1:0] live;

	// servo channel map, index 0 is channel zero
	localparam int RSV_N         = 2;
	localparam int RSV_EN[RSV_N] = '{SFSE_BIT_RSV_Z, SFSE_BIT_RSV_O};
	localparam int RSV_OV[RSV_N] = '{SFSE_BIT_Z_OV, SFSE_BIT_O_OV};
	localparam int RSV_UV[RSV_N] = '{SFSE_BIT_Z_UV, SFSE_BIT_O_UV};

	// command decode and next-state pieces
	logic                    wr_enable;
	logic                    rd_latched;
	logic [SFSE_WORD_W-1:0]  enable_nxt;
	logic [SFSE_FAULT_W-1:0] latch_nxt;
	logic [RSV_N-1:0]        servo_on_v;
	logic [RSV_N-1:0]        repeat_v;
	logic [RSV_N-1:0]        monitor_v;
	logic [RSV_N-1:0]        rsv_ok;
	logic [RSV_N-1:0]        rsv_edge;

	// reset release through two flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= '0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'h1};
		end
	end
	assign rst_int_n = rst_sync_r[1];

	// R3: comparator tracking through the two-stage synchroniser
	sfse_sync #(
		.W (SFSE_FAULT_W)
	) u_fault_sync (
		.clk   (mclk),
		.rst_n (rst_int_n),
		.d     (fault_cond),
		.q     (live)
	);

	function automatic logic rising(input logic [SFSE_FAULT_W-1:0] now,
	                                input logic [SFSE_FAULT_W-1:0] prev,
	                                input int                      ov,
	                                input int                      uv);
		rising = (now[ov] & ~prev[ov]) | (now[uv] & ~prev[uv]);
	endfunction : rising

	// true when the strobed code matches the wanted command
	function automatic logic cmd_is(input logic [7:0] code,
	                                input logic [7:0] want);
		cmd_is = (code == want);
	endfunction : cmd_is

	// R10: command decode, a write wins over a read
	assign wr_enable  = cmd_wr & cmd_is(cmd_code, SFSE_CMD_ENABLE);
	assign rd_latched = ~cmd_wr & cmd_rd & cmd_is(cmd_code, SFSE_CMD_LATCHED);
	assign enable_nxt = wr_enable ? cmd_wdata : st_r.enable;

	// one latch cell per fault bit
	for (genvar b = 0; b < SFSE_FAULT_W; b++) begin : g_latch
		// R8: read clears, set still wins
		// R4: disabled bit forced zero
		// R5: enabled live fault sets latch
		// R9: enable clear drops latch
		assign latch_nxt[b] = ((st_r.latched[b] & ~rd_latched) | live[b]) & enable_nxt[b];
	end

	// servo qualifiers gathered per channel
	assign servo_on_v = {servo_enabled_one, servo_enabled_zero};
	assign repeat_v   = {repeat_servo_one, repeat_servo_zero};
	assign monitor_v  = {monitor_on_one, monitor_on_zero};

	// one re-servo trigger per servo channel
	for (genvar g = 0; g < RSV_N; g++) begin : g_rsv
		// R6: channel zero needs enable and qualifiers
		// R7: channel one needs enable and qualifiers
		assign rsv_ok[g]   = st_r.enable[RSV_EN[g]]
		                   & servo_on_v[g]
		                   & ~repeat_v[g]
		                   & monitor_v[g];
		// R11: edge triggered request
		assign rsv_edge[g] = rising(live, st_r.live_prev, RSV_OV[g], RSV_UV[g]);
	end

	always_comb begin
		st_nxt           = st_r;
		st_nxt.live_prev = live;
		st_nxt.enable    = enable_nxt;
		st_nxt.latched   = latch_nxt;
		st_nxt.ack       = 1'h0;
		st_nxt.nack      = 1'h0;
		st_nxt.req_zero  = rsv_ok[0] & rsv_edge[0];
		st_nxt.req_one   = rsv_ok[1] & rsv_edge[1];

		// R10: every strobe answered once
		if (cmd_wr) begin
			st_nxt.ack  = wr_enable;
			st_nxt.nack = ~wr_enable;
		end else if (cmd_rd) begin
			st_nxt.ack = 1'h1;
			unique case (cmd_code)
				// R1: reserved bits zero
				SFSE_CMD_LIVE: begin
					st_nxt.rdata = {SFSE_RSVD_ZERO, live};
				end
				SFSE_CMD_ENABLE: begin
					st_nxt.rdata = st_r.enable;
				end
				SFSE_CMD_LATCHED: begin
					st_nxt.rdata = {SFSE_RSVD_ZERO, st_r.latched};
				end
				default: begin
					st_nxt.rdata = SFSE_WORD_ZERO;
					st_nxt.ack   = 1'h0;
					st_nxt.nack  = 1'h1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			st_r        <= '0;
			st_r.enable <= SFSE_ENABLE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// R2: live output is the synchroniser flop
	assign live_fault_status    = live;
	assign latched_fault_status = st_r.latched;
	assign fault_latch_enable   = st_r.enable;
	assign cmd_rdata            = st_r.rdata;
	assign cmd_ack              = st_r.ack;
	assign cmd_nack             = st_r.nack;
	assign reservo_req_zero     = st_r.req_zero;
	assign reservo_req_one      = st_r.req_one;

endmodule : sfse_top

// ### sfse_pkg.sv
// constants for the supply fault status and enable register pair
// assumes a command/word port fed by an SMBus byte engine on mclk
package sfse_pkg;

	// command codes
	localparam logic [7:0]  SFSE_CMD_LIVE     = 8'h00;
	localparam logic [7:0]  SFSE_CMD_ENABLE   = 8'h08;
	localparam logic [7:0]  SFSE_CMD_LATCHED  = 8'h11;

	// widths
	localparam int          SFSE_WORD_W       = 16;
	localparam int          SFSE_FAULT_W      = 14;
	localparam int          SFSE_RSVD_W       = SFSE_WORD_W - SFSE_FAULT_W;

	// live fault bit positions used by the re-servo logic
	localparam int          SFSE_BIT_Z_OV     = 0;
	localparam int          SFSE_BIT_Z_UV     = 1;
	localparam int          SFSE_BIT_O_OV     = 5;
	localparam int          SFSE_BIT_O_UV     = 6;

	// enable register servo bits
	localparam int          SFSE_BIT_RSV_Z    = 14;
	localparam int          SFSE_BIT_RSV_O    = 15;

	// reset values
	localparam logic [15:0] SFSE_ENABLE_RST   = 16'h0000;
	localparam logic [15:0] SFSE_WORD_ZERO    = 16'h0000;
	localparam logic [13:0] SFSE_FAULT_ZERO   = 14'h0000;
	localparam logic [1:0]  SFSE_RSVD_ZERO    = 2'h0;

endpackage : sfse_pkg

// ### sfse_sync.sv
// two-stage synchroniser bank for asynchronous fault comparator levels
// assumes a reset already released synchronously to clk
module sfse_sync
	import sfse_pkg::*;
#(
	parameter int W = SFSE_FAULT_W
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sfse_sync_s;

	sfse_sync_s st_r;
	sfse_sync_s st_nxt;

	always_comb begin
		st_nxt.meta   = d;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.stable;

endmodule : sfse_sync

// ### sfse_monitor.sv
// port assertions for the supply fault register pair
// assumes bind onto sfse_top, one mclk domain, rst_n low resets
module sfse_monitor
	import sfse_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// command port
	input wire logic        cmd_rd,
	input wire logic        cmd_wr,
	input wire logic [7:0]  cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata,
	input wire logic        cmd_ack,
	input wire logic        cmd_nack,
	// servo qualifiers
	input wire logic        servo_enabled_zero,
	input wire logic        repeat_servo_zero,
	input wire logic        monitor_on_zero,
	input wire logic        servo_enabled_one,
	input wire logic        repeat_servo_one,
	input wire logic        monitor_on_one,
	// fault state
	input wire logic [13:0] fault_cond,
	input wire logic [13:0] live_fault_status,
	input wire logic [13:0] latched_fault_status,
	input wire logic [15:0] fault_latch_enable,
	input wire logic        reservo_req_zero,
	input wire logic        reservo_req_one
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_ANSWER: assert property ((cmd_rd | cmd_wr) |=> (cmd_ack ^ cmd_nack))
		else $error("command not answered once");
	AST_WR_BAD: assert property ((cmd_wr && cmd_code != SFSE_CMD_ENABLE) |=>
		cmd_nack && $stable(fault_latch_enable)) else $error("bad write taken");
	AST_WR_EN: assert property ((cmd_wr && cmd_code == SFSE_CMD_ENABLE) |=>
		fault_latch_enable == $past(cmd_wdata)) else $error("enable not written");
	AST_LIVE_RD: assert property ((cmd_rd && !cmd_wr && cmd_code == SFSE_CMD_LIVE) |=>
		cmd_rdata == {2'h0, $past(live_fault_status)}) else $error("live read wrong");
	AST_FOLLOW: assert property ($stable(fault_cond)[*3] |-> live_fault_status == fault_cond)
		else $error("live bits not following");
	AST_MASK: assert property ((latched_fault_status & ~fault_latch_enable[13:0]) == 14'h0)
		else $error("disabled latch bit set");
	AST_SET: assert property (!cmd_wr |=>
		($past(live_fault_status & fault_latch_enable[13:0]) & ~latched_fault_status) == 14'h0)
		else $error("enabled fault not latched");
	AST_LAT_RD: assert property ((cmd_rd && !cmd_wr && cmd_code == SFSE_CMD_LATCHED) |=>
		latched_fault_status == ($past(live_fault_status) & fault_latch_enable[13:0]))
		else $error("latched read did not clear");
	AST_RSV_ZERO: assert property (($rose(live_fault_status[0]) && fault_latch_enable[14] &&
		servo_enabled_zero && !repeat_servo_zero && monitor_on_zero) |=> reservo_req_zero)
		else $error("re-servo zero missing");
	AST_RSV_ONE: assert property (!(fault_latch_enable[15] && !repeat_servo_one) |=>
		!reservo_req_one) else $error("re-servo one not allowed");
	AST_RSV_ONE_SET: assert property (($rose(live_fault_status[6]) && fault_latch_enable[15] &&
		servo_enabled_one && !repeat_servo_one && monitor_on_one) |=> reservo_req_one)
		else $error("re-servo one missing");
endmodule : sfse_monitor
bind sfse_top sfse_monitor mon_u (
	.mclk                 (mclk),
	.rst_n                (rst_n),
	.cmd_rd               (cmd_rd),
	.cmd_wr               (cmd_wr),
	.cmd_code             (cmd_code),
	.cmd_wdata            (cmd_wdata),
	.cmd_rdata            (cmd_rdata),
	.cmd_ack              (cmd_ack),
	.cmd_nack             (cmd_nack),
	.servo_enabled_zero   (servo_enabled_zero),
	.repeat_servo_zero    (repeat_servo_zero),
	.monitor_on_zero      (monitor_on_zero),
	.servo_enabled_one    (servo_enabled_one),
	.repeat_servo_one     (repeat_servo_one),
	.monitor_on_one       (monitor_on_one),
	.fault_cond           (fault_cond),
	.live_fault_status    (live_fault_status),
	.latched_fault_status (latched_fault_status),
	.fault_latch_enable   (fault_latch_enable),
	.reservo_req_zero     (reservo_req_zero),
	.reservo_req_one      (reservo_req_one)
);

// ### sfse_host.sv
// command port driver standing in for the SMBus byte engine
// assumes sfse_top command timing, strobes changed at falling mclk
module sfse_host
	import sfse_pkg::*;
(
	// clock
	input  wire logic        mclk,
	// answer from the block
	input  wire logic        cmd_ack,
	input  wire logic        cmd_nack,
	input  wire logic [15:0] cmd_rdata,
	// request to the block
	output logic             cmd_rd    = 1'h0,
	output logic             cmd_wr    = 1'h0,
	output logic [7:0]       cmd_code  = 8'h00,
	output logic [15:0]      cmd_wdata = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] wd,
		output logic [15:0] d, output logic nk, output logic ok);
		ok = 1'h0;
		@(negedge mclk);
		{cmd_code, cmd_wdata, cmd_wr, cmd_rd} = {c, wd, w, !w};
		@(negedge mclk);
		{cmd_code, cmd_wdata, cmd_wr, cmd_rd} = {~c, ~wd, 2'h0};
		for (int i = 0; i < 4 && !ok; i++) begin
			if (cmd_ack | cmd_nack) begin
				{ok, nk, d} = {1'h1, cmd_nack, cmd_rdata};
			end else begin
				@(negedge mclk);
			end
		end
	endtask : xfer
endmodule : sfse_host

// ### tb.sv
// self-checking bench for the supply fault status and enable registers
// assumes sfse_top and the host model, mclk at 25 MHz
module tb;
	import sfse_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'h0, rst_n = 1'h0, cmd_rd, cmd_wr, cmd_ack, cmd_nack, nk;
	logic        servo_enabled_zero = 1'h1, repeat_servo_zero = 1'h0, monitor_on_zero = 1'h1;
	logic        servo_enabled_one = 1'h1, repeat_servo_one = 1'h0, monitor_on_one = 1'h1;
	logic        reservo_req_zero, reservo_req_one;
	logic [7:0]  cmd_code;
	logic [13:0] fault_cond = 14'h0000, live_fault_status, latched_fault_status;
	logic [15:0] cmd_wdata, cmd_rdata, fault_latch_enable, d;
	int          miscompares = 0, num_checks = 0, n0 = 0, n1 = 0;
	sfse_top dut_u (
		.mclk                 (mclk),
		.rst_n                (rst_n),
		.fault_cond           (fault_cond),
		.servo_enabled_zero   (servo_enabled_zero),
		.repeat_servo_zero    (repeat_servo_zero),
		.monitor_on_zero      (monitor_on_zero),
		.servo_enabled_one    (servo_enabled_one),
		.repeat_servo_one     (repeat_servo_one),
		.monitor_on_one       (monitor_on_one),
		.cmd_code             (cmd_code),
		.cmd_rd               (cmd_rd),
		.cmd_wr               (cmd_wr),
		.cmd_wdata            (cmd_wdata),
		.cmd_rdata            (cmd_rdata),
		.cmd_ack              (cmd_ack),
		.cmd_nack             (cmd_nack),
		.live_fault_status    (live_fault_status),
		.latched_fault_status (latched_fault_status),
		.fault_latch_enable   (fault_latch_enable),
		.reservo_req_zero     (reservo_req_zero),
		.reservo_req_one      (reservo_req_one)
	);
	sfse_host host_u (
		.mclk      (mclk),
		.cmd_ack   (cmd_ack),
		.cmd_nack  (cmd_nack),
		.cmd_rdata (cmd_rdata),
		.cmd_rd    (cmd_rd),
		.cmd_wr    (cmd_wr),
		.cmd_code  (cmd_code),
		.cmd_wdata (cmd_wdata)
	);
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		n0 <= n0 + int'(reservo_req_zero);
		n1 <= n1 + int'(reservo_req_one);
	end
	task automatic test_done;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic xf(input logic w, input logic [7:0] c, input logic [15:0] wd);
		logic ok;
		host_u.xfer(w, c, wd, d, nk, ok);
		if (!ok) begin
			miscompares++;
			test_done();
		end
	endtask : xf
	task automatic rdc(input logic [7:0] c, input logic [15:0] e);
		xf(1'h0, c, 16'h0000);
		chk(d, e);
	endtask : rdc
	initial begin
		repeat (4) @(negedge mclk);
		rst_n = 1'h1;
		repeat (3) @(negedge mclk);
		rdc(SFSE_CMD_ENABLE, SFSE_ENABLE_RST);
		rdc(SFSE_CMD_LIVE, 16'h0000);
		xf(1'h1, SFSE_CMD_LIVE, 16'hFFFF);
		chk({15'h0000, nk}, 16'h0001);
		rdc(8'h20, 16'h0000);
		chk({15'h0000, nk}, 16'h0001);
		xf(1'h1, SFSE_CMD_ENABLE, 16'h3FFF);
		rdc(SFSE_CMD_ENABLE, 16'h3FFF);
		fault_cond = 14'h0421;
		repeat (4) @(negedge mclk);
		rdc(SFSE_CMD_LIVE, 16'h0421);
		rdc(SFSE_CMD_LATCHED, 16'h0421);
		rdc(SFSE_CMD_LATCHED, 16'h0421);
		fault_cond = 14'h0000;
		repeat (4) @(negedge mclk);
		rdc(SFSE_CMD_LIVE, 16'h0000);
		rdc(SFSE_CMD_LATCHED, 16'h0421);
		rdc(SFSE_CMD_LATCHED, 16'h0000);
		fault_cond = 14'h0400;
		repeat (4) @(negedge mclk);
		chk({2'h0, latched_fault_status}, 16'h0400);
		xf(1'h1, SFSE_CMD_ENABLE, 16'hC000);
		chk({2'h0, latched_fault_status}, 16'h0000);
		rdc(SFSE_CMD_LATCHED, 16'h0000);
		fault_cond = 14'h0041;
		repeat (6) @(negedge mclk);
		chk(16'(n0), 16'h0001);
		chk(16'(n1), 16'h0001);
		repeat_servo_one = 1'h1;
		fault_cond = 14'h0000;
		repeat (4) @(negedge mclk);
		fault_cond = 14'h0041;
		repeat (6) @(negedge mclk);
		chk(16'(n0), 16'h0002);
		chk(16'(n1), 16'h0001);
		test_done();
	end
endmodule : tb
